// [lptc_timer.sv]
// low power timer counter with axi4-lite register slave
`default_nettype none
module lptc_timer #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [3:0] clk_src,
   input wire logic [3:0] pulse_in,
   output logic trigger,
   output logic irq
);
   import lptc_pkg::*;

   // the counter and the read path are served for widths of 1 to 32 bits only
   if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_w_check
      $error("CNT_W must be 1..32");
   end

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for external clock sources and pulse inputs
   logic [3:0] src_s1_q;
   logic [3:0] src_s2_q;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         src_s1_q <= 4'h0;
         src_s2_q <= 4'h0;
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         src_s1_q <= clk_src;
         src_s2_q <= src_s1_q;
         pin_s1_q <= pulse_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   lptc_ctrl_t ctrl_q;
   lptc_psc_t psc_q;
   logic [CNT_W-1:0] cmp_q;
   logic [CNT_W-1:0] cnt_q;
   logic flag_q;
   logic trig_q;
   logic irq_q;

   logic aw_hold_q;
   logic w_hold_q;
   logic awready_q;
   logic wready_q;
   logic arready_q;
   logic [3:0] aw_addr_q;
   logic aw_bad_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic wr_fire;
   logic flag_clr_wr;
   logic [3:0] wr_addr;
   logic wr_bad;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   // address and data may arrive in either order; each is held until both are in
   assign wr_addr = aw_hold_q ? aw_addr_q : awaddr[3:0];
   assign wr_bad = aw_hold_q ? aw_bad_q : (awaddr[31:4] != 28'h0 || awaddr[1:0] != 2'h0);
   assign wr_data = w_hold_q ? w_data_q : wdata;
   assign wr_strb = w_hold_q ? w_strb_q : wstrb;
   assign wr_fire = (aw_hold_q || awvalid) && (w_hold_q || wvalid) && !bvalid_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 4'h0;
         aw_bad_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= LPTC_RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
      end else begin
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bresp_q <= wr_bad ? LPTC_RESP_SLVERR : LPTC_RESP_OKAY;
         end else begin
            // ready flops mirror the next hold and response state, so the ports come from registers
            awready_q <= !(aw_hold_q || (awvalid && awready_q)) && !(bvalid_q && !bready);
            wready_q <= !(w_hold_q || (wvalid && wready_q)) && !(bvalid_q && !bready);
            if (awvalid && awready) begin
               aw_hold_q <= 1'b1;
               aw_addr_q <= awaddr[3:0];
               aw_bad_q <= awaddr[31:4] != 28'h0 || awaddr[1:0] != 2'h0;
            end
            if (wvalid && wready) begin
               w_hold_q <= 1'b1;
               w_data_q <= wdata;
               w_strb_q <= wstrb;
            end
            if (bvalid_q && bready) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   assign flag_clr_wr = wr_fire && !wr_bad && wr_addr == LPTC_CTRL_OFS && wr_strb[0]
                        && wr_data[LPTC_FLAG_BIT];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= '0;
         psc_q <= '{value: 4'h0, prescale_clock_sel: LPTC_CLK_RST, prescale_bypass: 1'b1};
         cmp_q <= '0;
      end else if (wr_fire && !wr_bad) begin
         if (wr_addr == LPTC_CTRL_OFS && wr_strb[0]) begin
            ctrl_q.enable <= wr_data[LPTC_EN_BIT];
            ctrl_q.count_mode_sel <= lptc_mode_t'(wr_data[LPTC_MODE_BIT]);
            ctrl_q.free_run_en <= wr_data[LPTC_FREE_BIT];
            ctrl_q.pulse_input_polarity <= wr_data[LPTC_POL_BIT];
            ctrl_q.pulse_input_sel <= wr_data[LPTC_SEL_LSB +: 2];
            ctrl_q.compare_irq_en <= wr_data[LPTC_IRQEN_BIT];
         end else if (wr_addr == LPTC_PSC_OFS && wr_strb[0]) begin
            psc_q <= wr_data[6:0];
         end else if (wr_addr == LPTC_CMP_OFS) begin
            cmp_q <= wr_data[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock select, prescaler and glitch filter
   logic clk_lvl;
   logic clk_prev_q;
   logic clk_rise;
   logic [15:0] psc_cnt_q;
   logic psc_tick;
   logic pin_lvl;
   logic filt_q;
   logic filt_prev_q;
   logic [15:0] filt_cnt_q;
   logic [15:0] filt_len;
   logic tick;

   assign clk_lvl = src_s2_q[psc_q.prescale_clock_sel];
   assign clk_rise = clk_lvl && !clk_prev_q;
   // divide by 2^(value+1): tick when the low value+1 bits of the edge count wrap
   assign psc_tick = clk_rise && ((psc_cnt_q | ~((16'h2 << psc_q.value) - 16'h1)) == 16'hffff);
   assign filt_len = 16'h1 << psc_q.value;
   assign pin_lvl = pin_s2_q[ctrl_q.pulse_input_sel] ^ ctrl_q.pulse_input_polarity;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clk_prev_q <= 1'b0;
         psc_cnt_q <= 16'h0;
      end else begin
         clk_prev_q <= clk_lvl;
         if (!ctrl_q.enable) begin
            psc_cnt_q <= 16'h0;
         end else if (clk_rise) begin
            psc_cnt_q <= psc_cnt_q + 16'h1;
         end
      end
   end

   // filter counts selected-clock edges while the raw level differs from the filtered one
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         filt_q <= 1'b0;
         filt_prev_q <= 1'b0;
         filt_cnt_q <= 16'h0;
      end else begin
         filt_prev_q <= filt_q;
         if (pin_lvl == filt_q || !ctrl_q.enable) begin
            filt_cnt_q <= 16'h0;
            if (!ctrl_q.enable) begin
               filt_q <= pin_lvl;
            end
         end else if (psc_q.prescale_bypass || psc_q.value == 4'h0) begin
            filt_q <= pin_lvl; // no filter for bypass or setting 0
         end else if (clk_rise) begin
            if (filt_cnt_q + 16'h1 >= filt_len) begin
               filt_q <= pin_lvl;
               filt_cnt_q <= 16'h0;
            end else begin
               filt_cnt_q <= filt_cnt_q + 16'h1;
            end
         end
      end
   end

   always_comb begin
      if (ctrl_q.count_mode_sel == LPTC_MODE_PULSE) begin
         tick = filt_q && !filt_prev_q;
      end else if (psc_q.prescale_bypass) begin
         tick = clk_rise;
      end else begin
         tick = psc_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter, compare flag, trigger and interrupt
   logic match_q;
   logic hit;
   // a stale match in the cycle after a stop must not raise a late flag or trigger
   assign hit = tick && match_q && ctrl_q.enable;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         match_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         cnt_q <= '0;
         match_q <= 1'b0;
      end else begin
         if (tick) begin
            if (hit && !ctrl_q.free_run_en) begin
               cnt_q <= '0;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
         match_q <= (tick ? ((hit && !ctrl_q.free_run_en) ? '0 : cnt_q + 1'b1) : cnt_q) == cmp_q;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
         trig_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         trig_q <= hit;
         if (hit) begin
            flag_q <= 1'b1;
         end else if (flag_clr_wr || !ctrl_q.enable) begin
            flag_q <= 1'b0;
         end
         irq_q <= (flag_q || hit) && ctrl_q.compare_irq_en && ctrl_q.enable
                  && !(flag_clr_wr && !hit);
      end
   end
   assign trigger = trig_q;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // read channel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= LPTC_RESP_OKAY;
         arready_q <= 1'b1;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         arready_q <= 1'b0;
         rresp_q <= LPTC_RESP_OKAY;
         rdata_q <= 32'h0;
         if (araddr[31:4] != 28'h0 || araddr[1:0] != 2'h0) begin
            rresp_q <= LPTC_RESP_SLVERR;
         end else if (araddr[3:0] == LPTC_CTRL_OFS) begin
            rdata_q <= {24'h0, flag_q, ctrl_q};
         end else if (araddr[3:0] == LPTC_PSC_OFS) begin
            rdata_q <= {25'h0, psc_q};
         end else if (araddr[3:0] == LPTC_CMP_OFS) begin
            rdata_q[CNT_W-1:0] <= cmp_q;
         end else begin
            rdata_q[CNT_W-1:0] <= cnt_q;
         end
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
endmodule : lptc_timer
`default_nettype wire

// [lptc_pkg.sv]
// package for the low power timer counter: register map, fields, modes
`default_nettype none
package lptc_pkg;
   localparam logic [3:0] LPTC_CTRL_OFS = 4'h0;
   localparam logic [3:0] LPTC_PSC_OFS = 4'h4;
   localparam logic [3:0] LPTC_CMP_OFS = 4'h8;
   localparam logic [3:0] LPTC_CNT_OFS = 4'hc;
   // ctrl fields
   localparam int LPTC_EN_BIT = 0;
   localparam int LPTC_MODE_BIT = 1;
   localparam int LPTC_FREE_BIT = 2;
   localparam int LPTC_POL_BIT = 3;
   localparam int LPTC_SEL_LSB = 4;
   localparam int LPTC_IRQEN_BIT = 6;
   localparam int LPTC_FLAG_BIT = 7;
   // prescale fields
   localparam int LPTC_BYP_BIT = 0;
   localparam int LPTC_CLK_LSB = 1;
   localparam int LPTC_VAL_LSB = 3;
   localparam logic [1:0] LPTC_CLK_RST = 2'h1;
   localparam logic [1:0] LPTC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LPTC_RESP_SLVERR = 2'h2;
   typedef enum logic {
      LPTC_MODE_TIME = 1'b0,
      LPTC_MODE_PULSE = 1'b1
   } lptc_mode_t;
   typedef struct packed {
      logic compare_irq_en;
      logic [1:0] pulse_input_sel;
      logic pulse_input_polarity;
      logic free_run_en;
      lptc_mode_t count_mode_sel;
      logic enable;
   } lptc_ctrl_t;
   typedef struct packed {
      logic [3:0] value;
      logic [1:0] prescale_clock_sel;
      logic prescale_bypass;
   } lptc_psc_t;
endpackage : lptc_pkg
`default_nettype wire

// [lptc_chk_sva.sv]
// checker for bus answers, trigger width and interrupt fall of the timer
`default_nettype none
module lptc_chk
   import lptc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] araddr,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic trigger,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wbad;
   logic rbad;
   logic cwr;
   assign wbad = (awaddr[31:4] != 28'h0) || (awaddr[1:0] != 2'h0);
   assign rbad = (araddr[31:4] != 28'h0) || (araddr[1:0] != 2'h0);
   assign cwr = !wbad && (awaddr[3:0] == LPTC_CTRL_OFS);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////
   sequence wr_go;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rd_go;
      arvalid && arready;
   endsequence
   AST_B_LAT: assert property (wr_go |=> bvalid)
      else $error("write answer late");
   AST_WR_ERR: assert property (wr_go ##0 wbad |=> bresp == LPTC_RESP_SLVERR)
      else $error("bad write address accepted");
   AST_R_LAT: assert property (rd_go |=> rvalid)
      else $error("read answer late");
   AST_R_ERR: assert property (rd_go ##0 rbad |=> rdata == 32'h0 && rresp == LPTC_RESP_SLVERR)
      else $error("bad read address accepted");
   AST_R_OK: assert property (rd_go ##0 !rbad |=> rresp == LPTC_RESP_OKAY)
      else $error("good read refused");
   AST_TRIG_ONE: assert property (trigger |=> !trigger)
      else $error("trigger too wide");
   AST_IRQ_MASK: assert property (wr_go ##0 (cwr && !wdata[LPTC_IRQEN_BIT]) |-> ##2 !irq)
      else $error("irq with enable clear");
   AST_STOP: assert property (wr_go ##0 (cwr && !wdata[LPTC_EN_BIT]) |-> ##2 (!irq && !trigger) [*4])
      else $error("events after stop");
endmodule : lptc_chk
bind lptc_timer lptc_chk u_lptc_chk (.clock(clock), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
   .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
   .trigger(trigger), .irq(irq));
`default_nettype wire

// [lptc_far.sv]
// far side model: four slow clock sources and four pulse inputs
`default_nettype none
module lptc_far (
   input wire logic clock,
   output logic [3:0] clk_src,
   output logic [3:0] pulse_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] div_q = 6'h0;
   logic idle_q = 1'b0;
   always_ff @(posedge clock) begin
      div_q <= div_q + 6'h1;
   end
   // source k runs at clock / 2^(k+2), slow enough for the input synchroniser
   assign clk_src = div_q[4:1];
   initial begin
      pulse_in = 4'h0;
   end
   // inputs rest at the inactive level, so an active low input rests high
   task automatic set_idle(input logic lvl);
      @(posedge clock);
      pulse_in <= {4{lvl}};
      idle_q <= lvl;
   endtask : set_idle
   task automatic pulse(input int ch, input int w);
      @(posedge clock);
      pulse_in[ch] <= !idle_q;
      repeat (w) @(posedge clock);
      pulse_in[ch] <= idle_q;
      repeat (w) @(posedge clock);
   endtask : pulse
endmodule : lptc_far
`default_nettype wire

// [lptc_timer_tb.sv]
// self-checking bench for the timer: registers, counting, filter and events
`default_nettype none
module lptc_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lptc_pkg::*;
   localparam logic [1:0] OK = LPTC_RESP_OKAY;
   localparam logic [1:0] ER = LPTC_RESP_SLVERR;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic bready = 1'b0;
   logic rready = 1'b0;
   logic [31:0] awaddr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] araddr = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [2:0] prot = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, trigger, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, ctl;
   logic [3:0] clk_src, pulse_in;
   int n_fail = 0;
   int total_checks = 0;
   int n_trig = 0;
   lptc_timer #(.CNT_W(16)) u_lptc_timer (.clock(clock), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(prot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .clk_src(clk_src),
      .pulse_in(pulse_in), .trigger(trigger), .irq(irq));
   lptc_far u_lptc_far (.clock(clock), .clk_src(clk_src), .pulse_in(pulse_in));
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (trigger === 1'b1) n_trig <= n_trig + 1;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      total_checks++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : check
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      bready <= 1'b0;
      check(32'(n), 32'h1, 32'h63);
      check({30'h0, bresp}, {30'h0, er}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] lo, input logic [31:0] hi);
      int n;
      n = 0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      rready <= 1'b0;
      check(32'(n), 32'h1, 32'h63);
      check({30'h0, rresp}, {30'h0, er}, {30'h0, er});
      check(rdata, lo, hi);
   endtask : rd
   task automatic setup(input logic [31:0] c, input logic [31:0] psc, input logic [31:0] cmp);
      wr(32'h0, 32'h0, OK);
      wr(32'h4, psc, OK);
      wr(32'h8, cmp, OK);
      wr(32'h0, c, OK);
      n_trig = 0;
   endtask : setup
   // window of 160 cycles; one tick either way absorbs synchroniser delay
   task automatic run_time(input logic [31:0] psc, input int exp);
      setup(32'h1, psc, 32'hffff);
      repeat (160) @(posedge clock);
      rd(32'hc, OK, 32'(exp - 1), 32'(exp + 1));
   endtask : run_time
   task automatic finish_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      rd(32'h0, OK, 0, 0);
      rd(32'h4, OK, 3, 3);
      rd(32'h8, OK, 0, 0);
      rd(32'hc, OK, 0, 0);
      wr(32'h8, 32'h12345, OK);
      rd(32'h8, OK, 32'h2345, 32'h2345);
      wr(32'hc, 32'h5, OK);
      rd(32'hc, OK, 0, 0);
      wr(32'h10, 32'h1, ER);
      wr(32'h2, 32'h1, ER);
      rd(32'h10, ER, 0, 0);
      wr(32'h0, 32'h7e, OK);
      rd(32'h0, OK, 32'h7e, 32'h7e);
      wr(32'h4, 32'h7f, OK);
      rd(32'h4, OK, 32'h7f, 32'h7f);
      for (int s = 0; s < 4; s++) run_time(32'h1 | (s << 1), 160 >> (s + 2));
      for (int v = 0; v < 4; v++) run_time(v << 3, 160 >> (v + 3));
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            ctl = 32'h43 | (p << 3) | (s << 4);
            u_lptc_far.set_idle(p[0]);
            setup(ctl, 32'h1, 32'h3);
            u_lptc_far.pulse((s + 1) % 4, 4);
            repeat (3) u_lptc_far.pulse(s, 4);
            rd(32'hc, OK, 3, 3);
            check(n_trig, 0, 0);
            u_lptc_far.pulse(s, 4);
            check(n_trig, 1, 1);
            check(irq, 1, 1);
            rd(32'h0, OK, ctl | 32'h80, ctl | 32'h80);
            rd(32'hc, OK, 0, 0);
            wr(32'h0, ctl | 32'h80, OK);
            repeat (2) @(posedge clock);
            check(irq, 0, 0);
         end
      end
      u_lptc_far.set_idle(1'b0);
      setup(32'h7, 32'h1, 32'h1);
      repeat (3) u_lptc_far.pulse(0, 4);
      rd(32'hc, OK, 3, 3);
      check(n_trig, 1, 1);
      check(irq, 0, 0);
      wr(32'h0, 32'h47, OK);
      repeat (2) @(posedge clock);
      check(irq, 1, 1);
      wr(32'h0, 32'h0, OK);
      rd(32'h0, OK, 0, 0);
      rd(32'hc, OK, 0, 0);
      for (int v = 1; v < 3; v++) begin
         setup(32'h3, v << 3, 32'h5);
         u_lptc_far.pulse(0, 4 * (1 << v) - 6);
         rd(32'hc, OK, 0, 0);
         u_lptc_far.pulse(0, 16 << v);
         rd(32'hc, OK, 1, 1);
      end
      finish_test();
   end
endmodule : lptc_timer_tb
`default_nettype wire
